// *** logic/eic_pkg.sv ***
`default_nettype none
package eic_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int MAX_IN_KHZ    = 200;
   localparam int QUAD_EDGE_NS  = 1_000_000 / (4 * MAX_IN_KHZ);   // edge spacing at top input rate
   localparam int FILTER_NS     = 40;                             // least stable time of a pin
   localparam int FAULT_NS      = 5000;                           // least time a broken pair must persist
   localparam int SER_HALF_NS   = 50;                             // half period of the serial clock
   localparam int FILTER_CYC    = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QSTEP_CYC     = (QUAD_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_CYC     = (FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SER_HALF_CYC  = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W        = $clog2(FILTER_CYC + 1);
   localparam int QSTEP_W       = $clog2(QSTEP_CYC + 1);
   localparam int FAULT_W       = $clog2(FAULT_CYC + 1);
   localparam int SER_HALF_W    = $clog2(SER_HALF_CYC + 1);

   // ************************************************************
   // pins and widths
   // ************************************************************
   localparam int POS_W   = 12;
   localparam int BIT_W   = $clog2(POS_W + 1);
   localparam int PIN_A1P = 0;
   localparam int PIN_A1N = 1;
   localparam int PIN_B1P = 2;
   localparam int PIN_B1N = 3;
   localparam int PIN_Z1P = 4;
   localparam int PIN_Z1N = 5;
   localparam int PIN_A2P = 6;
   localparam int PIN_A2N = 7;
   localparam int PIN_B2P = 8;
   localparam int PIN_B2N = 9;
   localparam int PIN_Z2P = 10;
   localparam int PIN_Z2N = 11;
   localparam logic [POS_W-1:0] POS_ZERO = 12'h000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      EIC_QUAD_SINGLE,
      EIC_QUAD_DUAL,
      EIC_QUAD_REDUNDANT,
      EIC_ABS_GRAY_HI,
      EIC_ABS_BIN_HI,
      EIC_ABS_GRAY_LO,
      EIC_ABS_BIN_LO
   } eic_mode_e;

   typedef struct packed {
      logic family;      // installed = quadrature
      logic polarity;    // installed = extra inversion / no redundancy
      logic dual;        // installed = single / gray
   } eic_jumper_s;

   typedef struct packed {
      logic a_p;
      logic a_n;
      logic b_p;
      logic b_n;
      logic z_p;
      logic z_n;
   } eic_quad_s;

   // ************************************************************
   // functions
   // ************************************************************
   function automatic eic_mode_e eic_decode_mode(input eic_jumper_s j);
      eic_mode_e m;
      m = EIC_QUAD_SINGLE;
      if (j.family) begin
         if (j.polarity && !j.dual) m = EIC_QUAD_DUAL;
         else if (!j.polarity && !j.dual) m = EIC_QUAD_REDUNDANT;
         else m = EIC_QUAD_SINGLE;
      end else begin
         if (j.polarity) m = j.dual ? EIC_ABS_GRAY_HI : EIC_ABS_BIN_HI;
         else m = j.dual ? EIC_ABS_GRAY_LO : EIC_ABS_BIN_LO;
      end
      return m;
   endfunction

   function automatic logic [POS_W-1:0] eic_gray_to_bin(input logic [POS_W-1:0] g);
      logic [POS_W-1:0] b;
      b = '0;
      b[POS_W-1] = g[POS_W-1];
      for (int i = POS_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic eic_quad_s eic_diff(input logic a, input logic b, input logic z);
      eic_quad_s q;
      q.a_p = a;
      q.a_n = ~a;
      q.b_p = b;
      q.b_n = ~b;
      q.z_p = z;
      q.z_n = ~z;
      return q;
   endfunction

endpackage
`default_nettype wire

// *** logic/eic_serializer.sv ***
`default_nettype none
// shifts one position word out msb first, framed, with its own bit clock
module eic_serializer
   import eic_pkg::*;
(
   input  wire  logic                   mclk,
   input  wire  logic                   reset_n,
   input  wire  logic                   load,
   input  wire  logic [eic_pkg::POS_W-1:0] word,
   output logic                         ready,
   output logic                         ser_clk,
   output logic                         ser_data,
   output logic                         ser_frame
);

   logic [POS_W-1:0]      shift;
   logic [POS_W-1:0]      next_shift;
   logic [BIT_W-1:0]      bits;
   logic [BIT_W-1:0]      next_bits;
   logic [SER_HALF_W-1:0] half;
   logic [SER_HALF_W-1:0] next_half;
   logic                  next_ready;
   logic                  next_ser_clk;
   logic                  next_ser_data;
   logic                  next_ser_frame;

   // ************************************************************
   // shift engine
   // ************************************************************
   // data changes on the falling serial edge, stable at the rising one
   always_comb begin
      next_shift     = shift;
      next_bits      = bits;
      next_half      = half;
      next_ready     = ready;
      next_ser_clk   = ser_clk;
      next_ser_data  = ser_data;
      next_ser_frame = ser_frame;
      if (ready) begin
         if (load) begin
            next_shift     = {word[POS_W-2:0], 1'b0};
            next_ser_data  = word[POS_W-1];
            next_bits      = BIT_W'(POS_W);
            next_half      = SER_HALF_W'(SER_HALF_CYC - 1);
            next_ready     = 1'b0;
            next_ser_frame = 1'b1;
         end
      end else if (half != '0) begin
         next_half = half - 1'b1;
      end else begin
         next_half    = SER_HALF_W'(SER_HALF_CYC - 1);
         next_ser_clk = ~ser_clk;
         if (ser_clk) begin
            next_bits = bits - 1'b1;
            if (bits == BIT_W'(1)) begin
               next_ser_frame = 1'b0;
               next_ser_data  = 1'b0;
               next_ready     = 1'b1;
            end else begin
               next_ser_data = shift[POS_W-1];
               next_shift    = {shift[POS_W-2:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         shift     <= '0;
         bits      <= '0;
         half      <= '0;
         ready     <= 1'b1;
         ser_clk   <= 1'b0;
         ser_data  <= 1'b0;
         ser_frame <= 1'b0;
      end else begin
         shift     <= next_shift;
         bits      <= next_bits;
         half      <= next_half;
         ready     <= next_ready;
         ser_clk   <= next_ser_clk;
         ser_data  <= next_ser_data;
         ser_frame <= next_ser_frame;
      end
   end

endmodule
`default_nettype wire

// *** logic/eic_top.sv ***
`default_nettype none
module eic_top
   import eic_pkg::*;
(
   input  wire  logic                      mclk,
   input  wire  logic                      reset_n,
   input  wire  eic_pkg::eic_jumper_s      jumpers,
   input  wire  logic [eic_pkg::POS_W-1:0] enc_pins,
   input  wire  logic                      encoder_select,
   output logic                            drive_processor_module_quad_valid,
   output eic_pkg::eic_quad_s              quad_out,
   output logic [eic_pkg::POS_W-1:0]       position,
   output eic_pkg::eic_mode_e              mode,
   output logic                            active_encoder,
   output logic                            failover_flag,
   output logic                            ser_clk,
   output logic                            ser_data,
   output logic                            ser_frame
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [POS_W-1:0]  filt;
   logic [POS_W-1:0]  next_filt;
   logic [FILT_W-1:0] filt_cnt [POS_W];
   logic [FILT_W-1:0] next_filt_cnt [POS_W];
   logic [POS_W-1:0]  prev_pins;
   eic_mode_e         next_mode;
   logic              next_failover_flag;
   logic              next_active_encoder;
   logic [FAULT_W-1:0] fault_cnt;
   logic [FAULT_W-1:0] next_fault_cnt;
   logic              primary_broken;
   eic_quad_s         next_quad_out;
   logic              next_quad_valid;
   logic [POS_W-1:0]  next_position;
   logic [POS_W-1:0]  emu;
   logic [POS_W-1:0]  next_emu;
   logic [POS_W-1:0]  emu_gap;
   logic [QSTEP_W-1:0] qstep;
   logic [QSTEP_W-1:0] next_qstep;
   logic              is_abs;
   logic [POS_W-1:0]  word_in;
   logic              ser_ready;
   logic              ser_load;

   // true in the four positional modes; gates both the follower and the link
   function automatic logic mode_is_abs(input eic_mode_e m);
      return m inside {EIC_ABS_GRAY_HI, EIC_ABS_BIN_HI, EIC_ABS_GRAY_LO, EIC_ABS_BIN_LO};
   endfunction

   // ************************************************************
   // input filter
   // ************************************************************
   // a pin must hold a new level for the filter time, well under the
   // shortest quadrature edge spacing at the top input rate
   always_comb begin
      next_filt = filt;
      for (int i = 0; i < POS_W; i++) begin
         next_filt_cnt[i] = filt_cnt[i];
         if (enc_pins[i] != prev_pins[i] || enc_pins[i] == filt[i]) begin
            next_filt_cnt[i] = '0;
         end else if (filt_cnt[i] == FILT_W'(FILTER_CYC - 1)) begin
            next_filt[i]     = enc_pins[i];
            next_filt_cnt[i] = '0;
         end else begin
            next_filt_cnt[i] = filt_cnt[i] + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         filt      <= '0;
         prev_pins <= '0;
         for (int i = 0; i < POS_W; i++) begin
            filt_cnt[i] <= '0;
         end
      end else begin
         filt      <= next_filt;
         prev_pins <= enc_pins;
         for (int i = 0; i < POS_W; i++) begin
            filt_cnt[i] <= next_filt_cnt[i];
         end
      end
   end

   // ************************************************************
   // mode decode and failover
   // ************************************************************
   // a differential pair whose legs agree is a broken wire or encoder
   assign primary_broken = (filt[PIN_A1P] == filt[PIN_A1N]) || (filt[PIN_B1P] == filt[PIN_B1N]);

   always_comb begin
      next_mode           = eic_decode_mode(jumpers);
      next_failover_flag  = failover_flag;
      next_fault_cnt      = '0;
      next_active_encoder = 1'b0;
      if (next_mode == EIC_QUAD_REDUNDANT && !failover_flag) begin
         if (primary_broken) begin
            next_fault_cnt = fault_cnt + 1'b1;
            if (fault_cnt == FAULT_W'(FAULT_CYC - 1)) begin
               next_failover_flag = 1'b1;
            end
         end
      end
      if (next_mode == EIC_QUAD_DUAL) begin
         next_active_encoder = encoder_select;
      end else if (failover_flag || next_failover_flag) begin
         next_active_encoder = 1'b1;
      end
   end

   // the failover flag has no clear path but reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode           <= EIC_QUAD_SINGLE;
         failover_flag  <= 1'b0;
         fault_cnt      <= '0;
         active_encoder <= 1'b0;
      end else begin
         mode           <= next_mode;
         failover_flag  <= next_failover_flag;
         fault_cnt      <= next_fault_cnt;
         active_encoder <= next_active_encoder;
      end
   end

   // ************************************************************
   // positional word
   // ************************************************************
   // the pins arrive already inverted by the input stage; an installed
   // polarity jumper undoes that, a removed one leaves it, which also
   // serves to reverse a backwards-mounted encoder
   assign is_abs  = !jumpers.family;
   assign word_in = jumpers.polarity ? ~filt : filt;

   always_comb begin
      next_position = position;
      if (is_abs) begin
         if (jumpers.dual) begin
            next_position = eic_gray_to_bin(word_in);
         end else begin
            next_position = word_in;
         end
      end
   end

   // ************************************************************
   // pseudo quadrature follower
   // ************************************************************
   // the emulated count walks one step per edge slot toward the position,
   // taking the short way round the wrap
   assign emu_gap = position - emu;

   always_comb begin
      next_emu   = emu;
      next_qstep = qstep;
      if (qstep != '0) begin
         next_qstep = qstep - 1'b1;
      end else if (mode_is_abs(mode) && emu_gap != '0) begin
         next_emu   = emu_gap[POS_W-1] ? emu - 1'b1 : emu + 1'b1;
         next_qstep = QSTEP_W'(QSTEP_CYC - 1);
      end
   end

   // ************************************************************
   // quadrature output
   // ************************************************************
   always_comb begin
      next_quad_valid = 1'b1;
      next_quad_out   = eic_diff(~filt[PIN_A1P], ~filt[PIN_B1P], ~filt[PIN_Z1P]);
      case (mode)
         EIC_QUAD_SINGLE: begin
            next_quad_out = eic_diff(~filt[PIN_A1P], ~filt[PIN_B1P], ~filt[PIN_Z1P]);
         end
         EIC_QUAD_DUAL, EIC_QUAD_REDUNDANT: begin
            if (active_encoder) begin
               next_quad_out = eic_diff(~filt[PIN_A2P], ~filt[PIN_B2P], ~filt[PIN_Z2P]);
            end
         end
         EIC_ABS_GRAY_HI, EIC_ABS_BIN_HI, EIC_ABS_GRAY_LO, EIC_ABS_BIN_LO: begin
            next_quad_out = eic_diff(emu[1], emu[1] ^ emu[0], emu == POS_ZERO);
         end
         default: begin
            next_quad_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         position                          <= '0;
         emu                               <= '0;
         qstep                             <= '0;
         quad_out                          <= '0;
         drive_processor_module_quad_valid <= 1'b0;
      end else begin
         position                          <= next_position;
         emu                               <= next_emu;
         qstep                             <= next_qstep;
         quad_out                          <= next_quad_out;
         drive_processor_module_quad_valid <= next_quad_valid;
      end
   end

   // ************************************************************
   // serial link to the processor
   // ************************************************************
   // a new frame starts as soon as the last one ends, carrying the latest word
   assign ser_load = ser_ready && mode_is_abs(mode);

   eic_serializer u_ser (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .load      (ser_load),
      .word      (position),
      .ready     (ser_ready),
      .ser_clk   (ser_clk),
      .ser_data  (ser_data),
      .ser_frame (ser_frame)
   );

endmodule
`default_nettype wire

// *** testbench/eic_enc_model.sv ***
`default_nettype none
// ************
// shaft encoder: absolute word or two quadrature encoders
// ************
module eic_enc_model
   import eic_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      abs_mode,
   input  wire logic                      low_true,
   input  wire logic [eic_pkg::POS_W-1:0] code,
   input  wire logic [2:0]                q1,
   input  wire logic [2:0]                q2,
   input  wire logic                      fault,
   output var  logic [eic_pkg::POS_W-1:0] enc_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [POS_W-1:0] level;

   // encoder output level: a high-true zero is all bits low
   always_comb level = low_true ? ~code : code;

   // pins as seen behind the inverting opto stage; q = {a, b, z}
   // a fault shorts the primary a pair so both legs read alike
   always @(posedge mclk) begin
      if (abs_mode) enc_pins <= ~level;
      else enc_pins <= {q2[0], ~q2[0], q2[1], ~q2[1], q2[2], ~q2[2],
                        q1[0], ~q1[0], q1[1], ~q1[1], fault ? ~q1[2] : q1[2], ~q1[2]};
   end
endmodule
`default_nettype wire

// *** testbench/eic_top_chk.sv ***
`default_nettype none
// ************
// port checker
// ************
module eic_top_chk
   import eic_pkg::*;
(
   input wire logic                      mclk,
   input wire logic                      reset_n,
   input wire eic_pkg::eic_jumper_s      jumpers,
   input wire logic [eic_pkg::POS_W-1:0] enc_pins,
   input wire logic                      encoder_select,
   input wire logic                      drive_processor_module_quad_valid,
   input wire eic_pkg::eic_quad_s        quad_out,
   input wire logic [eic_pkg::POS_W-1:0] position,
   input wire eic_pkg::eic_mode_e        mode,
   input wire logic                      active_encoder,
   input wire logic                      failover_flag,
   input wire logic                      ser_clk,
   input wire logic                      ser_data,
   input wire logic                      ser_frame
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       in_abs;
   logic [7:0] frame_cnt;
   logic [7:0] next_frame_cnt;

   // only absolute modes may frame
   assign in_abs = mode inside {EIC_ABS_GRAY_HI, EIC_ABS_BIN_HI, EIC_ABS_GRAY_LO, EIC_ABS_BIN_LO};

   // cycles spent inside the current frame
   always_comb next_frame_cnt = ser_frame ? frame_cnt + 8'h01 : 8'h00;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) frame_cnt <= 8'h00;
      else frame_cnt <= next_frame_cnt;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   chk_flag_sticky: assert property (failover_flag |=> failover_flag)
      else $error("failover flag dropped");
   chk_flag_cause: assert property ($rose(failover_flag) |-> $past(mode) == EIC_QUAD_REDUNDANT)
      else $error("failover outside redundant mode");
   chk_flag_switch: assert property ($rose(failover_flag) |-> $rose(active_encoder))
      else $error("failover without switch to backup");
   chk_fail_latch: assert property (failover_flag && mode != EIC_QUAD_DUAL && $past(mode) != EIC_QUAD_DUAL
      |-> active_encoder) else $error("backup released after failover");
   chk_dual_follow: assert property (mode == EIC_QUAD_DUAL && $past(mode) == EIC_QUAD_DUAL
      && $stable(encoder_select) |-> active_encoder == encoder_select) else $error("dual select ignored");
   chk_single_primary: assert property (mode == EIC_QUAD_SINGLE && $past(mode) == EIC_QUAD_SINGLE
      && !failover_flag |-> !active_encoder) else $error("single mode not on primary");
   chk_frame_len: assert property ($fell(ser_frame) && in_abs |-> frame_cnt == 8'h78)
      else $error("frame length wrong");
   chk_frame_abs: assert property ($rose(ser_frame) |-> $past(in_abs))
      else $error("frame in quadrature mode");
   chk_data_edge: assert property (ser_frame && $past(ser_frame) && $changed(ser_data) |-> $fell(ser_clk))
      else $error("serial data moved off the falling clock");
   chk_diff_pairs: assert property (drive_processor_module_quad_valid && $past(drive_processor_module_quad_valid)
      |-> quad_out.a_n != quad_out.a_p && quad_out.b_n != quad_out.b_p && quad_out.z_n != quad_out.z_p)
      else $error("quadrature legs not complementary");
endmodule

bind eic_top eic_top_chk eic_top_chk_i (
   .mclk(mclk), .reset_n(reset_n), .jumpers(jumpers), .enc_pins(enc_pins),
   .encoder_select(encoder_select), .drive_processor_module_quad_valid(drive_processor_module_quad_valid),
   .quad_out(quad_out), .position(position), .mode(mode), .active_encoder(active_encoder),
   .failover_flag(failover_flag), .ser_clk(ser_clk), .ser_data(ser_data), .ser_frame(ser_frame)
);
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); \
   end \
end
// ************
// bench for the encoder conditioner
// ************
module testbench import eic_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic             mclk = 1'h0;
   logic             reset_n = 1'h0;
   eic_jumper_s      jumpers = 3'h7;
   logic             encoder_select = 1'h0;
   logic             abs_mode = 1'h0;
   logic             low_true = 1'h0;
   logic             fault = 1'h0;
   logic [POS_W-1:0] code = 12'h000;
   logic [2:0]       q1 = 3'h0;
   logic [2:0]       q2 = 3'h0;
   logic [POS_W-1:0] enc_pins;
   logic             valid;
   eic_quad_s        quad_out;
   logic [POS_W-1:0] position;
   eic_mode_e        mode;
   logic             active_encoder;
   logic             failover_flag;
   logic             ser_clk;
   logic             ser_data;
   logic             ser_frame;
   int               n_errors = 0;
   int               checks_done = 0;
   int               frames_seen = 0;
   logic [31:0]      seed = 32'h54;
   logic [11:0]      exp_q[$];
   logic [2:0]       qseq[4] = '{3'h1, 3'h4, 3'h6, 3'h2};
   eic_mode_e        mtab[8] = '{EIC_ABS_BIN_LO, EIC_ABS_GRAY_LO, EIC_ABS_BIN_HI, EIC_ABS_GRAY_HI,
                                 EIC_QUAD_REDUNDANT, EIC_QUAD_SINGLE, EIC_QUAD_DUAL, EIC_QUAD_SINGLE};

   always #5 mclk = ~mclk;

   eic_top eic_top_i (
      .mclk(mclk), .reset_n(reset_n), .jumpers(jumpers), .enc_pins(enc_pins),
      .encoder_select(encoder_select), .drive_processor_module_quad_valid(valid),
      .quad_out(quad_out), .position(position), .mode(mode), .active_encoder(active_encoder),
      .failover_flag(failover_flag), .ser_clk(ser_clk), .ser_data(ser_data), .ser_frame(ser_frame));

   eic_enc_model eic_enc_model_i (
      .mclk(mclk), .abs_mode(abs_mode), .low_true(low_true), .code(code),
      .q1(q1), .q2(q2), .fault(fault), .enc_pins(enc_pins));

   // ************
   // helpers
   // ************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected differential set for channel levels {a, b, z}
   function automatic eic_quad_s qx(input logic [2:0] v);
      return {v[2], ~v[2], v[1], ~v[1], v[0], ~v[0]};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic finish_test();
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // present a word in the given code, check position, note the serial word
   task automatic abs_case(input logic [2:0] j, input logic lt, input logic [11:0] b, input logic [11:0] e);
      int f0;
      @(posedge mclk);
      jumpers <= j;
      abs_mode <= 1'h1;
      low_true <= lt;
      code <= j[0] ? b ^ (b >> 1) : b;
      cyc(12);
      #1;
      `CHK(position, e)
      f0 = frames_seen;
      exp_q.push_back(e);
      for (int k = 0; k < 400 && frames_seen == f0; k++) @(posedge mclk);
      if (frames_seen == f0) begin
         n_errors++;
         finish_test();
      end
   endtask

   // serial monitor: samples settled outputs each mclk edge; oldest note is
   // taken at frame start, bits msb first at each rising serial clock
   initial begin
      logic [11:0] want;
      logic [11:0] got;
      logic        clk_d;
      logic        frm_d;
      int          nb;
      want = 12'h000;
      got = 12'h000;
      clk_d = 1'h0;
      frm_d = 1'h0;
      nb = -1;
      forever begin
         @(posedge mclk);
         if (ser_frame && !frm_d && exp_q.size() > 0) begin
            want = exp_q.pop_front();
            nb = 0;
         end else if (nb >= 0 && ser_clk && !clk_d) begin
            got = {got[10:0], ser_data};
            nb++;
         end
         if (nb == 12) begin
            `CHK(got, want)
            frames_seen++;
            nb = -1;
         end
         clk_d = ser_clk;
         frm_d = ser_frame;
      end
   end

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      finish_test();
   end

   // ************
   // main sequence
   // ************
   initial begin
      logic [11:0] r;
      cyc(5);
      reset_n <= 1'h1;
      cyc(2);
      #1;
      `CHK(valid, 1'h1)
      `CHK(mode, EIC_QUAD_SINGLE)
      // pseudo quadrature walks the count toward the position
      abs_case(3'h3, 1'h0, 12'h000, 12'h000);
      cyc(20);
      #1;
      `CHK(quad_out, qx(3'h1))
      abs_case(3'h3, 1'h0, 12'h002, 12'h002);
      cyc(300);
      #1;
      `CHK(quad_out, qx(3'h6))
      abs_case(3'h3, 1'h0, 12'h001, 12'h001);
      cyc(150);
      #1;
      `CHK(quad_out, qx(3'h2))
      // every jumper setting
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         jumpers <= eic_jumper_s'(i[2:0]);
         abs_mode <= !i[2];
         cyc(3);
         #1;
         `CHK(mode, mtab[i])
      end
      // all four codes with random words, then a reversed polarity
      for (int i = 0; i < 8; i++) begin
         r = 12'(rnd());
         abs_case(3'(i % 4), !i[1], r, r);
      end
      abs_case(3'h2, 1'h1, r, ~r);
      // primary encoder stepping at the top input rate
      @(posedge mclk);
      jumpers <= 3'h7;
      abs_mode <= 1'h0;
      foreach (qseq[k]) begin
         @(posedge mclk);
         q1 <= qseq[k];
         cyc(10);
         #1;
         `CHK(quad_out, qx(qseq[k]))
         cyc(114);
      end
      // dual encoders, drive selects
      @(posedge mclk);
      jumpers <= 3'h6;
      q2 <= 3'h5;
      encoder_select <= 1'h1;
      cyc(12);
      #1;
      `CHK(active_encoder, 1'h1)
      `CHK(quad_out, qx(3'h5))
      @(posedge mclk);
      encoder_select <= 1'h0;
      cyc(6);
      #1;
      `CHK(quad_out, qx(3'h2))
      // redundant: a short fault is ignored, a long one fails over for good
      @(posedge mclk);
      jumpers <= 3'h4;
      fault <= 1'h1;
      cyc(200);
      fault <= 1'h0;
      cyc(20);
      #1;
      `CHK(failover_flag, 1'h0)
      @(posedge mclk);
      fault <= 1'h1;
      cyc(530);
      #1;
      `CHK(failover_flag, 1'h1)
      `CHK(quad_out, qx(3'h5))
      @(posedge mclk);
      fault <= 1'h0;
      jumpers <= 3'h7;
      cyc(20);
      #1;
      `CHK(active_encoder, 1'h1)
      `CHK(failover_flag, 1'h1)
      @(posedge mclk);
      reset_n <= 1'h0;
      cyc(2);
      reset_n <= 1'h1;
      cyc(3);
      #1;
      `CHK(failover_flag, 1'h0)
      `CHK(active_encoder, 1'h0)
      `CHK(mode, EIC_QUAD_SINGLE)
      finish_test();
   end
endmodule
`undef CHK
`default_nettype wire
